// file: asnu_alarm_unit.sv
// asnu_alarm_unit: live status, sticky notify, mask and alarm pin logic
`timescale 1ns/1ns
module asnu_alarm_unit
    import asnu_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire asnu_defects_t defects_in, // raw defect levels, async
    input wire logic host_req, // one-cycle transaction strobe
    input wire asnu_txn_t host_txn, // direction, address, data
    input wire logic [NUM_GRP-1:0][7:0] alarm_sel, // notifies on pin
    output logic [7:0] rd_data, // read answer byte
    output logic rd_valid, // one-cycle read answer strobe
    output logic alarm_n // alarm pin, active low
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [NUM_GRP-1:0][7:0] raw_status;
    logic [NUM_GRP-1:0][7:0] sync1_r, sync1_nxt;
    logic [NUM_GRP-1:0][7:0] sync2_r, sync2_nxt;
    logic [NUM_GRP-1:0][7:0] prev_r, prev_nxt;
    logic [NUM_GRP-1:0][7:0] notify_r, notify_nxt;
    logic [NUM_GRP-1:0][7:0] mask_r, mask_nxt;
    logic [NUM_GRP-1:0][7:0] set_vec, clr_vec;
    logic [7:0] page_r, page_nxt;
    logic [4:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic alarm_n_r, alarm_n_nxt;
    logic wr_en, rd_en;
    asnu_hit_t hit;
    logic [7:0] rd_value;

    ////////////////////////////////////////////////////////////////////////
    // defect inputs placed at their register bit positions
    always_comb begin
        raw_status = '0;
        raw_status[0][XO_LOSS_BIT] = defects_in.crystal_osc_clock_loss;
        raw_status[1] = {defects_in.loop_holdover_freeze,
                         defects_in.loop_lock_loss};
        raw_status[2] = {defects_in.ref_input_clock_loss_or_drift,
                         defects_in.ref_input_clock_loss};
        raw_status[3] = {defects_in.ref_input_frequency_drift_coarse,
                         defects_in.ref_input_frequency_drift_fine};
        for (int i = 0; i < 4; i++) begin
            raw_status[4 + i][FAST_LOCK_BIT] =
                defects_in.loop_fast_lock[i];
            raw_status[4 + i][HO_VALID_BIT] =
                defects_in.loop_holdover_valid[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        wr_en = host_req && host_txn.dir[WR_DIR_BIT];
        rd_en = host_req && !host_txn.dir[WR_DIR_BIT];
        hit = asnu_decode(page_r, host_txn.addr);

        // two stages before anything looks at a defect
        sync1_nxt = raw_status;
        sync2_nxt = sync1_r;

        // divider standing in for the 4 MHz oscillator rate
        div_nxt = (div_r == RC_DIV_LAST) ? 5'h00 : div_r + 5'h01;
        tick_nxt = (div_r == RC_DIV_LAST);

        // edges are only judged on the slow tick, so a pulse shorter
        // than one tick period may be missed
        prev_nxt = tick_r ? sync2_r : prev_r;

        mask_nxt = mask_r;
        for (int g = 0; g < NUM_GRP; g++) begin
            set_vec[g] = '0;
            clr_vec[g] = '0;
            if (tick_r) begin
                set_vec[g] = sync2_r[g] & ~prev_r[g] & mask_r[g]
                           & GRP_IMPL[g];
            end
            if (wr_en && hit.kind == K_NOTIFY && hit.grp == 3'(g)) begin
                clr_vec[g] = host_txn.data;
            end
            if (wr_en && hit.kind == K_MASK && hit.grp == 3'(g)) begin
                mask_nxt[g] = host_txn.data;
            end
            // set is or-ed in last so a coincident clear loses
            notify_nxt[g] = (notify_r[g] & ~clr_vec[g])
                          | set_vec[g];
        end

        page_nxt = page_r;
        if (wr_en && host_txn.addr == ADDR_PAGE_SEL) begin
            page_nxt = host_txn.data;
        end

        // read mux; status is the synchronised live level
        rd_value = RD_UNMAPPED;
        if (host_txn.addr == ADDR_PAGE_SEL) begin
            rd_value = page_r;
        end else begin
            case (hit.kind)
                K_STATUS: rd_value = sync2_r[hit.grp]
                                   & GRP_IMPL[hit.grp];
                K_NOTIFY: rd_value = notify_r[hit.grp];
                K_MASK: rd_value = mask_r[hit.grp];
                default: rd_value = RD_UNMAPPED;
            endcase
        end
        rd_data_nxt = rd_en ? rd_value : rd_data_r;
        rd_valid_nxt = rd_en;

        // pin is the nor of the selected notifies
        alarm_n_nxt = ~|(notify_r & alarm_sel);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
            notify_r <= {NUM_GRP{NOTIFY_RESET}};
            mask_r <= {NUM_GRP{MASK_RESET}};
            page_r <= PAGE_RESET;
            div_r <= 5'h00;
            tick_r <= 1'b0;
            rd_data_r <= RD_UNMAPPED;
            rd_valid_r <= 1'b0;
            alarm_n_r <= 1'b1;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
            notify_r <= notify_nxt;
            mask_r <= mask_nxt;
            page_r <= page_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            alarm_n_r <= alarm_n_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign alarm_n = alarm_n_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_notify_sets: assert property (
        @(posedge ref_clk) disable iff (rst)
        (set_vec != '0) |=> ((notify_r & $past(set_vec)) == $past(set_vec))
    ) else $error("notify did not set on a status rising edge");

    a_mask_gates_set: assert property (
        @(posedge ref_clk) disable iff (rst)
        ##1 ((notify_r & ~$past(notify_r) & ~$past(sync2_r & ~prev_r
              & mask_r)) == '0)
    ) else $error("notify rose without a masked-in status edge");

    a_notify_holds: assert property (
        @(posedge ref_clk) disable iff (rst)
        ##1 (($past(notify_r) & ~notify_r & ~$past(clr_vec)) == '0)
    ) else $error("notify fell without a clearing write");

    a_clear_works: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clr_vec != '0) |=> ((notify_r & $past(clr_vec & ~set_vec)) == '0)
    ) else $error("write of one did not clear the notify");

    a_set_beats_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        ((set_vec & clr_vec) != '0)
            |=> ((notify_r & $past(set_vec & clr_vec))
                 == $past(set_vec & clr_vec))
    ) else $error("clearing write swallowed a coincident edge");

    a_reset_values: assert property (
        @(posedge ref_clk)
        $past(rst) && !rst |-> (notify_r == {NUM_GRP{NOTIFY_RESET}})
            && (mask_r == {NUM_GRP{MASK_RESET}})
    ) else $error("notify or mask not all ones after reset");

    a_tick_period: assert property (
        @(posedge ref_clk) disable iff (rst)
        tick_r |=> !tick_r [*8] ##17 tick_r
    ) else $error("slow tick period is not 25 cycles");

    a_no_set_off_tick: assert property (
        @(posedge ref_clk) disable iff (rst)
        !tick_r |=> ((notify_r & ~$past(notify_r)) == '0)
    ) else $error("notify set between slow ticks");

    a_alarm_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        (|(notify_r & alarm_sel)) |=> !alarm_n_r
    ) else $error("alarm pin high with a selected notify set");

    a_alarm_high: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(|(notify_r & alarm_sel)) |=> alarm_n_r
    ) else $error("alarm pin low with no selected notify");

    a_page_written: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_en && host_txn.addr == ADDR_PAGE_SEL
            |=> page_r == $past(host_txn.data)
    ) else $error("page select write not taken");

    a_page_persists: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(wr_en && host_txn.addr == ADDR_PAGE_SEL) |=> $stable(page_r)
    ) else $error("page changed without a page select write");

    a_read_answer: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_en |=> rd_valid_r ##1 !rd_valid_r || $past(rd_en)
    ) else $error("read answer strobe wrong");

    a_status_live: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_en && hit.kind == K_STATUS && host_txn.addr != ADDR_PAGE_SEL
            |=> rd_data_r == $past(sync2_r[hit.grp] & GRP_IMPL[hit.grp])
    ) else $error("status read is not the live level");

endmodule : asnu_alarm_unit

// file: asnu_alarm_unit_tb.sv
// asnu_alarm_unit_tb: self-checking bench for the alarm unit
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end end
module asnu_alarm_unit_tb
    import asnu_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    asnu_defects_t defects_in = '0;
    asnu_defects_t prev = '0;
    logic [NUM_GRP-1:0][7:0] alarm_sel = '0;
    logic host_req;
    logic rd_valid;
    logic alarm_n;
    asnu_txn_t host_txn;
    logic [7:0] rd_data;
    logic [7:0] got;
    logic [7:0] ntf [NUM_GRP];
    logic [7:0] msk [NUM_GRP];
    int n_errors = 0;
    int check_count = 0;

    always #5 ref_clk = ~ref_clk;

    asnu_alarm_unit uut (.ref_clk(ref_clk), .rst(rst),
        .defects_in(defects_in), .host_req(host_req),
        .host_txn(host_txn), .alarm_sel(alarm_sel), .rd_data(rd_data),
        .rd_valid(rd_valid), .alarm_n(alarm_n));
    asnu_host_model host (.ref_clk(ref_clk), .rd_data(rd_data),
        .rd_valid(rd_valid), .host_req(host_req), .host_txn(host_txn));

    ////////////////////////////////////////////////////////////////////////
    // reference model of the register groups
    function automatic logic [7:0] stat(int g, asnu_defects_t d);
        case (g)
            0: return {5'h00, d.crystal_osc_clock_loss, 2'h0};
            1: return {d.loop_holdover_freeze, d.loop_lock_loss};
            2: return {d.ref_input_clock_loss_or_drift,
                       d.ref_input_clock_loss};
            3: return {d.ref_input_frequency_drift_coarse,
                       d.ref_input_frequency_drift_fine};
            default: return {5'h00, d.loop_holdover_valid[g-4],
                             d.loop_fast_lock[g-4], 1'h0};
        endcase
    endfunction : stat

    function automatic logic [7:0] pg(int g);
        return (g < 2) ? 8'h00 : (g < 4) ? 8'h01 : 8'(g + 6);
    endfunction : pg

    function automatic logic [7:0] ba(int g);
        return (g < 4 && g % 2 == 0) ? 8'h02 : 8'h06;
    endfunction : ba

    task automatic chk_grp(int g);
        host.wr(ADDR_PAGE_SEL, pg(g));
        host.rd(ba(g), got);
        `CHK(got, stat(g, prev))
        host.rd(ba(g) + 8'h01, got);
        `CHK(got, ntf[g])
        host.rd(ba(g) + 8'h02, got);
        `CHK(got, msk[g])
        host.rd(ADDR_PAGE_SEL, got);
        `CHK(got, pg(g))
    endtask : chk_grp

    // off 0 status (ignored), 1 notify (write one clears), 2 mask
    task automatic wr_grp(int g, int off, logic [7:0] w);
        host.wr(ADDR_PAGE_SEL, pg(g));
        host.wr(ba(g) + 8'(off), w);
        if (off == 1) ntf[g] &= ~w;
        else if (off == 2) msk[g] = w;
    endtask : wr_grp

    task automatic chk_alarm();
        logic any;
        any = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        for (int g = 0; g < NUM_GRP; g++) any |= |(ntf[g] & alarm_sel[g]);
        `CHK(alarm_n, ~any)
    endtask : chk_alarm

    // defects held 30 cycles: longer than the 4 MHz sampling latency
    task automatic step(logic [36:0] v);
        @(posedge ref_clk);
        defects_in <= v;
        #1;
        for (int g = 0; g < NUM_GRP; g++)
            ntf[g] |= stat(g, defects_in) & ~stat(g, prev) & msk[g];
        prev = defects_in;
        repeat (30) @(posedge ref_clk);
    endtask : step

    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end

    initial begin
        void'($urandom(9));
        for (int g = 0; g < NUM_GRP; g++) begin
            ntf[g] = 8'hFF;
            msk[g] = 8'hFF;
        end
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        alarm_sel <= 64'({$urandom(), $urandom()});
        chk_alarm();
        for (int g = 0; g < NUM_GRP; g++) chk_grp(g);
        host.wr(ADDR_PAGE_SEL, 8'h02);
        host.rd(8'h03, got);
        `CHK(got, 8'h00)
        host.wr(ADDR_PAGE_SEL, 8'h00);
        host.rd(8'h05, got);
        `CHK(got, 8'h00)
        // start-up clear of every notify register, every mask written to all ones
        for (int g = 0; g < NUM_GRP; g++) begin
            wr_grp(g, 1, 8'hFF);
            wr_grp(g, 2, 8'hFF);
        end
        chk_alarm();
        for (int i = 0; i < 8; i++) begin
            for (int g = 0; g < NUM_GRP; g++) wr_grp(g, 2, 8'($urandom()));
            step((i % 2 == 1) ? 37'h0 : 37'({$urandom(), $urandom()}));
            for (int g = 0; g < NUM_GRP; g++) chk_grp(g);
            chk_alarm();
            // partial clears leave the zero-written bits standing
            for (int g = 0; g < NUM_GRP; g++) begin
                wr_grp(g, 1, 8'($urandom()));
                wr_grp(g, 0, 8'($urandom()));
            end
            chk_alarm();
        end
        final_report();
    end
endmodule : asnu_alarm_unit_tb

// file: asnu_host_model.sv
// asnu_host_model: register port driver standing in for the serial host
`timescale 1ns/1ns
module asnu_host_model
    import asnu_pkg::*;
(
    input wire logic ref_clk, // bench clock
    input wire logic [7:0] rd_data, // read answer byte
    input wire logic rd_valid, // read answer strobe
    output logic host_req, // transaction strobe
    output asnu_txn_t host_txn // direction, address, data
);
    initial begin
        host_req = 1'b0;
        host_txn = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one whole 24-bit transaction per call, never a burst
    task automatic xfer(input logic [7:0] dir, input logic [7:0] addr,
                        input logic [7:0] data);
        @(posedge ref_clk);
        host_req <= 1'b1;
        host_txn <= {dir, addr, data};
        @(posedge ref_clk);
        host_req <= 1'b0;
        // released bus shows garbage so stale values cannot pass
        host_txn <= ~host_txn;
    endtask : xfer

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        xfer(8'h01, addr, data);
    endtask : wr

    // answer is taken only in the one cycle that rd_valid stands
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        xfer(8'h00, addr, 8'h00);
        // rd_valid rose at the edge that took the request; look now
        #1;
        data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask : rd
endmodule : asnu_host_model

// file: asnu_pkg.sv
// asnu_pkg: constants, types and address decode for the alarm unit
package asnu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clocking
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int RC_FREQ_HZ = 4_000_000;
    localparam int RC_DIV = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam logic [4:0] RC_DIV_LAST = 5'(RC_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] ADDR_PAGE_SEL = 8'hFF;
    localparam logic [7:0] ADDR_LO_STATUS = 8'h02;
    localparam logic [7:0] ADDR_LO_NOTIFY = 8'h03;
    localparam logic [7:0] ADDR_LO_MASK = 8'h04;
    localparam logic [7:0] ADDR_HI_STATUS = 8'h06;
    localparam logic [7:0] ADDR_HI_NOTIFY = 8'h07;
    localparam logic [7:0] ADDR_HI_MASK = 8'h08;
    localparam logic [7:0] PAGE_GENERIC = 8'h00;
    localparam logic [7:0] PAGE_MONITOR = 8'h01;
    localparam logic [7:0] PAGE_LOOP_A = 8'h0A;
    localparam logic [7:0] PAGE_LOOP_D = 8'h0D;

    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] NOTIFY_RESET = 8'hFF;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int WR_DIR_BIT = 0;

    // groups: 0 xo, 1 loop lock/freeze, 2 input loss, 3 drift, 4..7 loops
    localparam int NUM_GRP = 8;
    localparam logic [2:0] GRP_LOOP_BASE = 3'h4;
    localparam int XO_LOSS_BIT = 2;
    localparam int FAST_LOCK_BIT = 1;
    localparam int HO_VALID_BIT = 2;
    localparam logic [7:0] XO_BITS = 8'h01 << XO_LOSS_BIT;
    localparam logic [7:0] LOOP_BITS =
        (8'h01 << FAST_LOCK_BIT) | (8'h01 << HO_VALID_BIT);
    localparam logic [NUM_GRP-1:0][7:0] GRP_IMPL = {
        LOOP_BITS, LOOP_BITS, LOOP_BITS, LOOP_BITS,
        8'hFF, 8'hFF, 8'hFF, XO_BITS};

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic crystal_osc_clock_loss;
        logic [3:0] loop_lock_loss;
        logic [3:0] loop_holdover_freeze;
        logic [3:0] ref_input_clock_loss;
        logic [3:0] ref_input_clock_loss_or_drift;
        logic [3:0] ref_input_frequency_drift_fine;
        logic [3:0] ref_input_frequency_drift_coarse;
        logic [3:0] loop_fast_lock;
        logic [3:0] loop_holdover_valid;
    } asnu_defects_t;

    // one host transaction: direction byte, address byte, data byte
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] addr;
        logic [7:0] data;
    } asnu_txn_t;

    typedef enum logic [1:0] {
        K_NONE, K_STATUS, K_NOTIFY, K_MASK
    } asnu_kind_t;

    typedef struct packed {
        asnu_kind_t kind;
        logic [2:0] grp;
    } asnu_hit_t;

    // maps page and address to a register group and kind
    function automatic asnu_hit_t asnu_decode(input logic [7:0] page,
                                              input logic [7:0] addr);
        asnu_hit_t h;
        logic hi;
        logic [7:0] loop_idx;
        h.kind = K_NONE;
        h.grp = 3'h0;
        hi = (addr >= ADDR_HI_STATUS);
        loop_idx = page - PAGE_LOOP_A;
        case (addr)
            ADDR_LO_STATUS, ADDR_HI_STATUS: h.kind = K_STATUS;
            ADDR_LO_NOTIFY, ADDR_HI_NOTIFY: h.kind = K_NOTIFY;
            ADDR_LO_MASK, ADDR_HI_MASK: h.kind = K_MASK;
            default: h.kind = K_NONE;
        endcase
        if (page == PAGE_GENERIC) begin
            h.grp = hi ? 3'h1 : 3'h0;
        end else if (page == PAGE_MONITOR) begin
            h.grp = hi ? 3'h3 : 3'h2;
        end else if (page >= PAGE_LOOP_A && page <= PAGE_LOOP_D && hi) begin
            h.grp = GRP_LOOP_BASE + {1'b0, loop_idx[1:0]};
        end else begin
            h.kind = K_NONE;
        end
        return h;
    endfunction : asnu_decode

endpackage : asnu_pkg
